// *** rtl/absm_ctrl.sv ***
// Master-side controller: local CPU to asynchronous system bus
`timescale 1ns/1ps
module absm_ctrl (
	input  wire logic clk,
	input  wire logic resetn,
	absm_if.ctrl      bus,
	input  wire logic offboard_select_n,
	input  wire logic cpu_as_n,
	input  wire logic external_error_in_n,
	input  wire logic bus_release_n,
	input  wire logic addr_delay_return_n,
	output logic      addr_delay_launch_n,
	output logic      local_dtack_n,
	output logic      local_bus_error_n,
	output logic      cpu_halt_n,
	output logic      owner
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic offb_s, as_s, exerr_s, rel_s, adret_s;
	logic gin_s, dtk_s, berr_s;

	absm_sync u_s0 (.clk(clk), .resetn(resetn),
		.d(offboard_select_n), .q(offb_s));
	absm_sync u_s1 (.clk(clk), .resetn(resetn), .d(cpu_as_n), .q(as_s));
	absm_sync u_s2 (.clk(clk), .resetn(resetn),
		.d(external_error_in_n), .q(exerr_s));
	absm_sync u_s3 (.clk(clk), .resetn(resetn),
		.d(bus_release_n), .q(rel_s));
	absm_sync u_s4 (.clk(clk), .resetn(resetn),
		.d(addr_delay_return_n), .q(adret_s));
	absm_sync u_s5 (.clk(clk), .resetn(resetn),
		.d(bus.bus_grant_in_n), .q(gin_s));
	absm_sync u_s6 (.clk(clk), .resetn(resetn),
		.d(bus.sys_dtack_n), .q(dtk_s));
	absm_sync u_s7 (.clk(clk), .resetn(resetn),
		.d(bus.sys_berr_n), .q(berr_s));

	// ----------------------------------------
	// State
	// ----------------------------------------
	absm_pkg::absm_state_type state_r, state_nxt;
	logic                     req_r, req_nxt;
	logic                     busy_r, busy_nxt;
	logic                     gout_r, gout_nxt;
	logic                     early_r, early_nxt;
	logic                     err_seen_r, err_seen_nxt;
	logic                     launch_r, launch_nxt;
	logic                     strobe_r, strobe_nxt;
	logic                     ldtk_r, ldtk_nxt;
	logic                     local_bus_error_n_r, local_bus_error_n_nxt;
	logic                     halt_r, halt_nxt;
	logic [absm_pkg::CNT_W-1:0] hold_r, hold_nxt;

	logic want;
	logic bus_free;
	assign want     = !offb_s && !as_s;
	assign bus_free = dtk_s && berr_s && bus.sys_as_n;

	always_comb begin
		state_nxt    = state_r;
		req_nxt      = req_r;
		busy_nxt     = busy_r;
		gout_nxt     = 1'b1;
		early_nxt    = early_r;
		err_seen_nxt = err_seen_r;
		launch_nxt   = launch_r;
		strobe_nxt   = strobe_r;
		ldtk_nxt     = 1'b1;
		local_bus_error_n_nxt    = 1'b1;
		halt_nxt     = 1'b1;
		hold_nxt     = hold_r;
		// Grant seen with no own request is passed on
		if (!gin_s && !req_r && !busy_r) begin
			gout_nxt  = 1'b0;
			early_nxt = 1'b1;
		end
		if (gin_s) begin
			early_nxt = 1'b0;
		end
		// Local-only cycle ending in external error
		if (offb_s && !as_s && !exerr_s) begin
			local_bus_error_n_nxt = 1'b0;
			halt_nxt  = err_seen_r;
		end
		// Local error cycle over: arm retry, or disarm after the second
		if (state_r == absm_pkg::ST_IDLE && !local_bus_error_n_r && as_s) begin
			err_seen_nxt = !err_seen_r;
		end
		unique case (state_r)
			absm_pkg::ST_IDLE: begin
				if (want) begin
					req_nxt   = 1'b1;
					state_nxt = absm_pkg::ST_REQ;
				end
			end
			absm_pkg::ST_REQ: begin
				// Grant arriving before request was passed, not taken
				if (!gin_s && !early_r) begin
					state_nxt = absm_pkg::ST_WAITBUS;
				end else if (as_s) begin
					req_nxt   = 1'b0;
					state_nxt = absm_pkg::ST_IDLE;
				end
			end
			absm_pkg::ST_WAITBUS: begin
				if (bus_free) begin
					busy_nxt  = 1'b1;
					req_nxt   = 1'b0;
					hold_nxt  = '0;
					launch_nxt = 1'b1;
					state_nxt = absm_pkg::ST_SETUP;
				end
			end
			absm_pkg::ST_SETUP: begin
				if (!adret_s) begin
					strobe_nxt = 1'b1;
					state_nxt  = absm_pkg::ST_STROBE;
				end
			end
			absm_pkg::ST_STROBE: begin
				if (!dtk_s) begin
					ldtk_nxt     = 1'b0;
					err_seen_nxt = 1'b0;
					state_nxt    = absm_pkg::ST_FINISH;
				end else if (!berr_s) begin
					local_bus_error_n_nxt    = 1'b0;
					halt_nxt     = err_seen_r;
					err_seen_nxt = !err_seen_r;
					state_nxt    = absm_pkg::ST_FINISH;
				end
			end
			absm_pkg::ST_FINISH: begin
				ldtk_nxt  = !dtk_s ? 1'b0 : 1'b1;
				local_bus_error_n_nxt = !berr_s ? 1'b0 : 1'b1;
				// Halt stands with the first error only
				halt_nxt  = (!berr_s && err_seen_r) ? 1'b0 : 1'b1;
				// Hold the strobes until the CPU drops its own
				if (as_s) begin
					strobe_nxt = 1'b0;
					launch_nxt = 1'b0;
					state_nxt  = absm_pkg::ST_HOLD;
				end
			end
			absm_pkg::ST_HOLD: begin
				if (hold_r < absm_pkg::CNT_W'(absm_pkg::BUSY_HOLD_CYC)) begin
					hold_nxt = hold_r + 1'b1;
				end else if (rel_s) begin
					busy_nxt  = 1'b0;
					state_nxt = absm_pkg::ST_IDLE;
				end else if (want && bus_free) begin
					launch_nxt = 1'b1;
					state_nxt  = absm_pkg::ST_SETUP;
				end
			end
			default: begin
				state_nxt = absm_pkg::ST_IDLE;
			end
		endcase
		if (state_r != absm_pkg::ST_HOLD) begin
			hold_nxt = (state_r == absm_pkg::ST_WAITBUS) ? '0 : hold_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= absm_pkg::ST_IDLE;
			req_r      <= 1'b0;
			busy_r     <= 1'b0;
			gout_r     <= 1'b1;
			early_r    <= 1'b0;
			err_seen_r <= 1'b0;
			launch_r   <= 1'b0;
			strobe_r   <= 1'b0;
			ldtk_r     <= 1'b1;
			local_bus_error_n_r    <= 1'b1;
			halt_r     <= 1'b1;
			hold_r     <= '0;
		end else begin
			state_r    <= state_nxt;
			req_r      <= req_nxt;
			busy_r     <= busy_nxt;
			gout_r     <= gout_nxt;
			early_r    <= early_nxt;
			err_seen_r <= err_seen_nxt;
			launch_r   <= launch_nxt;
			strobe_r   <= strobe_nxt;
			ldtk_r     <= ldtk_nxt;
			local_bus_error_n_r    <= local_bus_error_n_nxt;
			halt_r     <= halt_nxt;
			hold_r     <= hold_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.bus_request_n   = !req_r;
	assign bus.bus_grant_out_n = gout_r;
	assign bus.bus_busy_n      = !busy_r;
	assign bus.bus_busy_oe     = busy_r;
	assign bus.sys_as_n        = !strobe_r;
	assign bus.sys_as_oe       = busy_r;
	assign addr_delay_launch_n = !launch_r;
	assign local_dtack_n       = ldtk_r;
	assign local_bus_error_n   = local_bus_error_n_r;
	assign cpu_halt_n          = halt_r;
	assign owner               = busy_r;
endmodule

// *** pkg/absm_pkg.sv ***
// Shared constants and types for the system bus master controller pair
package absm_pkg;
	localparam int CLK_PERIOD_NS   = 10;
	// Address set-up loop and busy hold times
	localparam int ADDR_DELAY_NS   = 35;
	localparam int BUSY_HOLD_NS    = 90;
	localparam int BUSY_HOLD_CYC   =
		(BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_DELAY_CYC  =
		(ADDR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 4;
	localparam int BR_LEVELS       = 4;
	localparam logic [1:0] BR_LEVEL_RESET = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_REQ     = 3'h1,
		ST_WAITBUS = 3'h3,
		ST_SETUP   = 3'h2,
		ST_STROBE  = 3'h6,
		ST_FINISH  = 3'h7,
		ST_HOLD    = 3'h5
	} absm_state_type;
endpackage

// *** pkg/absm_if.sv ***
// Interface joining the controller end and the arbiter/slave end
`timescale 1ns/1ps
interface absm_if;
	logic bus_request_n;
	logic bus_grant_in_n;
	logic bus_grant_out_n;
	logic bus_busy_n;
	logic bus_busy_oe;
	logic sys_as_n;
	logic sys_as_oe;
	logic sys_dtack_n;
	logic sys_berr_n;

	modport ctrl (
		output bus_request_n,
		input  bus_grant_in_n,
		output bus_grant_out_n,
		output bus_busy_n,
		output bus_busy_oe,
		output sys_as_n,
		output sys_as_oe,
		input  sys_dtack_n,
		input  sys_berr_n
	);
	modport sys (
		input  bus_request_n,
		output bus_grant_in_n,
		input  bus_grant_out_n,
		input  bus_busy_n,
		input  bus_busy_oe,
		input  sys_as_n,
		input  sys_as_oe,
		output sys_dtack_n,
		output sys_berr_n
	);
endinterface

// *** rtl/absm_sync.sv ***
// Two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ps
module absm_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RESET_VAL;
			q      <= RESET_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** rtl/absm_sys.sv ***
// System end: arbiter for one of the four request levels and a simple slave
`timescale 1ns/1ps
module absm_sys (
	input  wire logic       clk,
	input  wire logic       resetn,
	absm_if.sys             bus,
	input  wire logic [3:0] other_request_n,
	input  wire logic       slave_error,
	output logic            higher_request_n
);
	logic req_s, busy_s, as_s, oreq_s, serr_s;
	logic grant_r, grant_nxt;
	logic dtk_r, dtk_nxt;
	logic berr_r, berr_nxt;

	absm_sync u_r (.clk(clk), .resetn(resetn),
		.d(bus.bus_request_n), .q(req_s));
	absm_sync u_b (.clk(clk), .resetn(resetn),
		.d(bus.bus_busy_n), .q(busy_s));
	absm_sync u_a (.clk(clk), .resetn(resetn),
		.d(bus.sys_as_n), .q(as_s));
	// Requester sharing our level further down the grant chain
	absm_sync u_o (.clk(clk), .resetn(resetn),
		.d(other_request_n[1]), .q(oreq_s));
	absm_sync #(.RESET_VAL(1'b0)) u_e (.clk(clk), .resetn(resetn),
		.d(slave_error), .q(serr_s));

	always_comb begin
		grant_nxt = grant_r;
		dtk_nxt   = 1'b0;
		berr_nxt  = 1'b0;
		// New arbitration only while busy is high
		if (busy_s && !(req_s && oreq_s) && !grant_r) begin
			grant_nxt = 1'b1;
		end
		if (!busy_s || (req_s && oreq_s)) begin
			grant_nxt = 1'b0;
		end
		if (!as_s) begin
			dtk_nxt  = !serr_s;
			berr_nxt = serr_s;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			grant_r <= 1'b0;
			dtk_r   <= 1'b0;
			berr_r  <= 1'b0;
		end else begin
			grant_r <= grant_nxt;
			dtk_r   <= dtk_nxt;
			berr_r  <= berr_nxt;
		end
	end

	assign bus.bus_grant_in_n = !grant_r;
	assign bus.sys_dtack_n    = !dtk_r;
	assign bus.sys_berr_n     = !berr_r;
	// Levels above ours merged to force release
	assign higher_request_n   = &other_request_n[3:2];
endmodule

// *** testbench/absm_properties.sv ***
// Wire-level checker for the controller and system end pair
`timescale 1ns/1ps
module absm_properties (
	input wire logic clk,
	input wire logic resetn,
	input wire logic bus_request_n,
	input wire logic bus_grant_in_n,
	input wire logic bus_grant_out_n,
	input wire logic bus_busy_n,
	input wire logic bus_busy_oe,
	input wire logic sys_as_n,
	input wire logic sys_as_oe,
	input wire logic sys_dtack_n,
	input wire logic sys_berr_n
);
	logic [3:0] busy_cnt_r;
	logic [3:0] busy_cnt_nxt;

	// Saturating count of busy-low cycles
	always_comb begin
		busy_cnt_nxt = busy_cnt_r;
		if (bus_busy_n)
			busy_cnt_nxt = 4'h0;
		else if (busy_cnt_r != 4'hF)
			busy_cnt_nxt = busy_cnt_r + 4'h1;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			busy_cnt_r <= 4'h0;
		else
			busy_cnt_r <= busy_cnt_nxt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence bus_free;
		sys_dtack_n && sys_berr_n;
	endsequence
	sequence slave_answer;
		!sys_dtack_n || !sys_berr_n;
	endsequence

	a_take_when_free: assert property (
		$fell(bus_busy_n) |-> sys_as_n ##0 bus_free)
		else $error("busy taken while bus not free");
	a_busy_after_req: assert property (
		$fell(bus_busy_n) |-> !$past(bus_request_n))
		else $error("busy without pending request");
	a_req_dropped: assert property (
		$fell(bus_busy_n) |-> ##[0:3] bus_request_n)
		else $error("request kept after bus taken");
	a_pass_no_busy: assert property (
		!bus_grant_out_n |-> bus_busy_n)
		else $error("busy driven while grant passed on");
	a_strobe_in_tenure: assert property (
		!sys_as_n |-> !bus_busy_n)
		else $error("strobe without bus ownership");
	a_addr_setup_gap: assert property (
		$fell(sys_as_n) |-> !$past(bus_busy_n, 3))
		else $error("strobe too soon after taking bus");
	a_strobe_end_ack: assert property (
		$rose(sys_as_n) |-> slave_answer)
		else $error("strobe ended without slave answer");
	a_busy_hold_time: assert property (
		$rose(bus_busy_n) |-> busy_cnt_r >= absm_pkg::BUSY_HOLD_CYC)
		else $error("busy released too early");
	a_oe_follows_drive: assert property (
		bus_busy_oe == !bus_busy_n && (sys_as_n || sys_as_oe))
		else $error("output enable does not match drive");
	a_grant_on_idle: assert property (
		$fell(bus_grant_in_n) |-> bus_busy_n)
		else $error("grant issued while bus busy");
endmodule

// *** testbench/async_system_bus_master_controller_bench.sv ***
// Self-checking bench for controller and system end
`timescale 1ns/1ps
module async_system_bus_master_controller_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic offboard_select_n = 1'b1;
	logic cpu_as_n = 1'b1;
	logic external_error_in_n = 1'b1;
	logic rel_n = 1'b1;
	logic [3:0] other_request_n = 4'hF;
	logic slave_error = 1'b0;
	logic [3:0] dly_r = 4'hF;
	logic addr_delay_launch_n, local_dtack_n, local_bus_error_n;
	logic cpu_halt_n, owner, higher_request_n;
	int failures = 0;
	int compares = 0;
	int cyc = 0;

	always #5 clk = ~clk;
	// External 35 ns address loop, four cycles
	always @(posedge clk) dly_r <= {dly_r[2:0], addr_delay_launch_n};

	absm_if bus_if ();
	absm_ctrl u_absm_ctrl (.clk(clk), .resetn(resetn), .bus(bus_if.ctrl),
		.offboard_select_n(offboard_select_n), .cpu_as_n(cpu_as_n),
		.external_error_in_n(external_error_in_n),
		.bus_release_n(rel_n | !higher_request_n),
		.addr_delay_return_n(dly_r[3]),
		.addr_delay_launch_n(addr_delay_launch_n),
		.local_dtack_n(local_dtack_n), .local_bus_error_n(local_bus_error_n),
		.cpu_halt_n(cpu_halt_n), .owner(owner));
	absm_sys u_absm_sys (.clk(clk), .resetn(resetn), .bus(bus_if.sys),
		.other_request_n(other_request_n), .slave_error(slave_error),
		.higher_request_n(higher_request_n));
	absm_properties u_absm_properties (.clk(clk), .resetn(resetn),
		.bus_request_n(bus_if.bus_request_n),
		.bus_grant_in_n(bus_if.bus_grant_in_n),
		.bus_grant_out_n(bus_if.bus_grant_out_n),
		.bus_busy_n(bus_if.bus_busy_n), .bus_busy_oe(bus_if.bus_busy_oe),
		.sys_as_n(bus_if.sys_as_n), .sys_as_oe(bus_if.sys_as_oe),
		.sys_dtack_n(bus_if.sys_dtack_n), .sys_berr_n(bus_if.sys_berr_n));

	task automatic end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Status vector: dtack, error, halt, owner
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic access(input logic off_n, input logic ext_n,
		input logic [3:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		offboard_select_n <= off_n;
		external_error_in_n <= ext_n;
		cpu_as_n <= 1'b0;
		@(negedge clk);
		while (local_dtack_n !== 1'b0 && local_bus_error_n !== 1'b0
			&& n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({local_dtack_n, local_bus_error_n, cpu_halt_n, owner}, exp);
		@(posedge clk);
		cpu_as_n <= 1'b1;
		offboard_select_n <= 1'b1;
		external_error_in_n <= 1'b1;
		n = 0;
		while ((local_dtack_n & local_bus_error_n) !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic wait_owner(input logic v);
		int n;
		n = 0;
		while (owner !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({3'h0, owner}, {3'h0, v});
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		int n;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		access(1'b0, 1'b1, 4'h7);
		wait_owner(1'b0);
		$display("test single cycle done");
		@(posedge clk);
		slave_error <= 1'b1;
		access(1'b0, 1'b1, 4'h9);
		access(1'b0, 1'b1, 4'hB);
		access(1'b0, 1'b1, 4'h9);
		slave_error <= 1'b0;
		access(1'b0, 1'b1, 4'h7);
		slave_error <= 1'b1;
		access(1'b0, 1'b1, 4'h9);
		slave_error <= 1'b0;
		access(1'b0, 1'b1, 4'h7);
		wait_owner(1'b0);
		$display("test retry done");
		access(1'b1, 1'b0, 4'h8);
		access(1'b1, 1'b0, 4'hA);
		$display("test local error done");
		rel_n <= 1'b0;
		access(1'b0, 1'b1, 4'h7);
		repeat (20) @(negedge clk);
		chk({3'h0, owner}, 4'h1);
		@(posedge clk);
		other_request_n <= 4'hB;
		wait_owner(1'b0);
		@(posedge clk);
		other_request_n <= 4'hF;
		access(1'b0, 1'b1, 4'h7);
		@(posedge clk);
		rel_n <= 1'b1;
		wait_owner(1'b0);
		$display("test hold done");
		@(posedge clk);
		other_request_n <= 4'hD;
		n = 0;
		while (bus_if.bus_grant_out_n !== 1'b0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({3'h0, bus_if.bus_grant_out_n}, 4'h0);
		@(posedge clk);
		other_request_n <= 4'hF;
		repeat (30) @(posedge clk);
		$display("test grant pass done");
		end_sim();
	end
endmodule
